/* hdl/csrap_port.sv */
/*
  control and status access port: takes single reads and writes from a master
  and forwards them to the core register space, answering with busy, read-valid
  and a sideband read timeout.
  assumes the register space answers reads with a one-cycle ack within 1000 cycles
  and takes writes with a one-cycle ack; all on ref_clk_i.
*/
`timescale 1ns/10ps
module csrap_port import csrap_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [CSRAP_AW-1:0] addr_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [CSRAP_DW-1:0] writedata_i,
  output logic [CSRAP_DW-1:0] readdata_o,
  output logic readdata_valid_o,
  output logic busy_o,
  output logic read_timeout_o,
  output logic [CSRAP_AW-1:0] core_addr_o,
  output logic [CSRAP_DW-1:0] core_wdata_o,
  output logic core_read_o,
  output logic core_write_o,
  input wire logic [CSRAP_DW-1:0] core_rdata_i,
  input wire logic core_ack_i
);
  // ----------------------------------------
  // signal declarations
  // ----------------------------------------
  csrap_req_t req;
  csrap_rsp_t rsp;
  csrap_rsp_t next_rsp;
  csrap_state_t state;
  csrap_state_t next_state;
  logic [CSRAP_AW-1:0] addr_q;
  logic [CSRAP_AW-1:0] next_addr;
  logic [CSRAP_DW-1:0] wdata_q;
  logic [CSRAP_DW-1:0] next_wdata;
  logic expired;
  logic take;
  logic take_read;
  logic take_write;
  logic read_done;
  logic write_done;
  logic done;
  logic done_q;
  logic next_done;
  logic in_idle;
  logic in_read;
  logic in_write;
  logic command;
  logic rsp_timeout;
  logic [CSRAP_DW-1:0] rsp_rdata;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // state test shared by the decode, the timer and the outputs
  function automatic logic state_is(input csrap_state_t cur, input csrap_state_t want);
    return cur == want;
  endfunction : state_is

  // word for the master: the core word on an ack, else the reset word
  function automatic logic [CSRAP_DW-1:0] pick_rdata(input logic ack, input logic [CSRAP_DW-1:0] word);
    return ack ? word : CSRAP_DATA_RST;
  endfunction : pick_rdata

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign req = '{read: read_i, write: write_i, addr: addr_i, wdata: writedata_i}; // [RL1]
  assign in_idle = state_is(state, CSRAP_IDLE);
  assign in_read = state_is(state, CSRAP_READ);
  assign in_write = state_is(state, CSRAP_WRITE);
  assign command = req.read || req.write;

  // the finished command still stands on the pins in the done cycle;
  // it is accepted there and must not be taken a second time
  assign take = in_idle && !done_q && command; // [RL11]

  // read wins if both commands arrive together
  assign take_read = take && req.read;
  assign take_write = take && !req.read;

  // ----------------------------------------
  // completion
  // ----------------------------------------
  assign read_done = in_read && (core_ack_i || expired); // [RL12]
  assign write_done = in_write && core_ack_i;
  assign done = read_done || write_done;
  assign next_done = done;

  // ----------------------------------------
  // response
  // ----------------------------------------
  // an ack in the expiry cycle still counts as a good read
  assign rsp_timeout = expired && !core_ack_i; // [RL6]
  assign rsp_rdata = pick_rdata(core_ack_i, core_rdata_i);

  always_comb begin
    next_rsp.valid = 1'b0;
    next_rsp.timeout = 1'b0;
    next_rsp.rdata = rsp.rdata;
    if (read_done) begin
      next_rsp.valid = 1'b1; // [RL3]
      next_rsp.timeout = rsp_timeout; // [RL6]
      next_rsp.rdata = rsp_rdata;
    end
  end

  // ----------------------------------------
  // request capture
  // ----------------------------------------
  assign next_addr = take ? req.addr : addr_q;
  assign next_wdata = take ? req.wdata : wdata_q;

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      CSRAP_IDLE: begin
        if (take_read) begin
          next_state = CSRAP_READ;
        end else if (take_write) begin
          next_state = CSRAP_WRITE;
        end
      end
      CSRAP_READ: begin
        if (read_done) begin
          next_state = CSRAP_IDLE; // [RL5]
        end
      end
      CSRAP_WRITE: begin
        if (write_done) begin
          next_state = CSRAP_IDLE; // [RL10]
        end
      end
      default: begin
        next_state = CSRAP_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= CSRAP_IDLE; // [RL8]
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // response register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp.valid <= 1'b0;
      rsp.timeout <= 1'b0;
      rsp.rdata <= CSRAP_DATA_RST;
    end else begin
      rsp <= next_rsp;
    end
  end

  // ----------------------------------------
  // request register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      wdata_q <= CSRAP_DATA_RST;
    end else begin
      addr_q <= next_addr;
      wdata_q <= next_wdata;
    end
  end

  // ----------------------------------------
  // done register
  // ----------------------------------------
  // marks the one cycle in which busy falls and the held command is accepted
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= next_done;
    end
  end

  // ----------------------------------------
  // read timer
  // ----------------------------------------
  csrap_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(in_read),
    .expired_o(expired)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // busy is low in the done cycle, together with read-valid after a read; a master that
  // holds its command there sees it accepted, not started again
  assign busy_o = !in_idle || take; // [RL2] [RL9]
  assign readdata_o = rsp.rdata;
  assign readdata_valid_o = rsp.valid; // [RL3]
  assign read_timeout_o = rsp.timeout; // [RL7]
  assign core_addr_o = addr_q;
  assign core_wdata_o = wdata_q;
  assign core_read_o = in_read; // [RL4]
  assign core_write_o = in_write;
endmodule : csrap_port

/* hdl/csrap_pkg.sv */
/*
  constants, types and the behaviour list of the control and status access port.
  assumes one status clock and a synchronous active-high reset.
*/
// Behaviour
// RL1 - 16-bit address, 32-bit write and read data
// RL2 - busy while port cannot take requests
// RL3 - pulse read-valid when read data usable
// RL4 - master keeps one read outstanding
// RL5 - non-pipelined slave, variable latency
// RL6 - fixed counter flags read timeout
// RL7 - timeout is a sideband signal
// RL8 - status clock; synchronous reset idles port
// RL9 - read-valid rises as busy falls
// RL10 - back-to-back mixed writes and reads work
// RL11 - master holds request while busy
// RL12 - timed-out read still releases busy
package csrap_pkg;
  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int unsigned CSRAP_AW = 16;
  localparam int unsigned CSRAP_DW = 32;
  localparam int unsigned CSRAP_CLK_HZ = 10000000;
  localparam int unsigned CSRAP_TO_US = 100;
  localparam int unsigned CSRAP_TO_CYC = (CSRAP_TO_US * (CSRAP_CLK_HZ / 1000000));
  localparam int unsigned CSRAP_CW = 12;
  localparam logic [CSRAP_CW-1:0] CSRAP_CNT_RST = 12'h000;
  localparam logic [CSRAP_DW-1:0] CSRAP_DATA_RST = 32'h0000_0000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [CSRAP_AW-1:0] addr;
    logic [CSRAP_DW-1:0] wdata;
  } csrap_req_t;

  typedef struct packed {
    logic valid;
    logic timeout;
    logic [CSRAP_DW-1:0] rdata;
  } csrap_rsp_t;

  typedef enum logic [2:0] {
    CSRAP_IDLE = 3'b001,
    CSRAP_WRITE = 3'b010,
    CSRAP_READ = 3'b100
  } csrap_state_t;
endpackage : csrap_pkg

/* hdl/csrap_timer.sv */
/*
  read timer of the access port: counts cycles of a pending read.
  assumes run comes from the port state machine.
*/
`timescale 1ns/10ps
module csrap_timer import csrap_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic expired_o
);
  logic [CSRAP_CW-1:0] count;
  logic [CSRAP_CW-1:0] next_count;

  // fixed limit, not programmable; only broken addresses should reach it
  assign next_count = run_i ? count + 12'h001 : CSRAP_CNT_RST; // [RL6]
  assign expired_o = run_i && (count == CSRAP_CW'(CSRAP_TO_CYC - 1)); // [RL6]

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count <= CSRAP_CNT_RST;
    end else begin
      count <= next_count;
    end
  end
endmodule : csrap_timer

/* sim/csrap_properties.sv */
/* port checker; bound into csrap_port, one clock */
`timescale 1ns/10ps
module csrap_properties (
  input ref_clk_i,
  input rst_i,
  input read_i,
  input write_i,
  input readdata_valid_o,
  input busy_o,
  input read_timeout_o,
  input core_read_o,
  input core_write_o,
  input core_ack_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_go; $rose(core_read_o); endsequence
  // cycles spent in the current read; the timer must end it before 1000
  logic [10:0] rd_len;
  always_ff @(posedge ref_clk_i) rd_len <= (rst_i || !core_read_o) ? 11'h000 : rd_len + 11'h001;
  property p_pl; readdata_valid_o |=> !readdata_valid_o; endproperty
  a_pl: assert property (p_pl) else $error("pulse");
  property p_rel; core_read_o |-> rd_len < 11'h3e8; endproperty
  a_rel: assert property (p_rel) else $error("stuck");
  property p_go; s_go |-> busy_o; endproperty
  a_go: assert property (p_go) else $error("go");
  property p_vb; readdata_valid_o |-> !busy_o; endproperty
  a_vb: assert property (p_vb) else $error("valid busy");
  property p_to; read_timeout_o |-> readdata_valid_o; endproperty
  a_to: assert property (p_to) else $error("timeout");
  property p_ack; core_read_o && core_ack_i |=> readdata_valid_o && !read_timeout_o; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_bsy; core_read_o || core_write_o |-> busy_o; endproperty
  a_bsy: assert property (p_bsy) else $error("busy");
  property p_idl; !(read_i || write_i || core_read_o || core_write_o) |-> !busy_o; endproperty
  a_idl: assert property (p_idl) else $error("idle");
  property p_fin; readdata_valid_o |-> $past(core_read_o) && !core_read_o; endproperty
  a_fin: assert property (p_fin) else $error("end");
  property p_wr; core_write_o && core_ack_i |=> !core_write_o && !readdata_valid_o; endproperty
  a_wr: assert property (p_wr) else $error("write");
endmodule : csrap_properties
bind csrap_port csrap_properties u_props (.*);

/* sim/csrap_regspace.sv */
/* register space model, 16 words; latency grows with address, upper addresses never answer */
`timescale 1ns/10ps
module csrap_regspace (
  input ref_clk_i,
  input rd_i,
  input wr_i,
  input [15:0] addr_i,
  input [31:0] wdata_i,
  output logic [31:0] rdata_o = 32'h0,
  output logic ack_o = 1'b0
);
  logic [31:0] mem [16];
  logic [6:0] cnt = 7'h00;
  always @(posedge ref_clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o; // no stale word outside an ack
    if (!(rd_i || wr_i) || ack_o) cnt <= 7'h00;
    else if (cnt != {addr_i[3:0], 3'h0}) cnt <= cnt + 7'h01;
    else if (addr_i[15:4] == 12'h000) begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i[3:0]];
      if (wr_i) mem[addr_i[3:0]] <= wdata_i;
    end
  end
endmodule : csrap_regspace

/* sim/csr_access_port_tb.sv */
/* bench of the access port; assumes the register space model and the bound checker */
`timescale 1ns/10ps
module csr_access_port_tb;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
  logic [15:0] addr_i = 16'h0, core_addr_o;
  logic [31:0] writedata_i = 32'h0, readdata_o, core_wdata_o, core_rdata_i;
  logic readdata_valid_o, busy_o, read_timeout_o, core_read_o, core_write_o, core_ack_i;
  int mismatches = 0, tests_run = 0;
  csrap_port uut (.*);
  csrap_regspace u_reg (.ref_clk_i, .rd_i(core_read_o), .wr_i(core_write_o), .addr_i(core_addr_o),
    .wdata_i(core_wdata_o), .rdata_o(core_rdata_i), .ack_o(core_ack_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("%0d checks %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // command held until busy is seen low; the edge after that accepts it
  task automatic acc(logic rd, logic [15:0] a, logic [31:0] d, logic to);
    int n = 0;
    {read_i, write_i, addr_i, writedata_i} = {rd, !rd, a, d};
    do begin
      @(posedge ref_clk_i);
      #10 n++;
    end while (busy_o !== 1'b0 && n < 1100);
    chk("valid_timeout", {readdata_valid_o, read_timeout_o}, {rd, to});
    chk("busy", busy_o, 32'h0);
    @(posedge ref_clk_i);
    #10;
  endtask : acc
  task automatic sc_mix();
    acc(1'b0, 16'h0003, 32'hc0de_0003, 1'b0);
    acc(1'b1, 16'h0003, 32'h0, 1'b0);
    chk("data", readdata_o, 32'hc0de_0003);
    acc(1'b0, 16'h0000, 32'h1234_abcd, 1'b0);
    acc(1'b1, 16'h0000, 32'h0, 1'b0);
    chk("data", readdata_o, 32'h1234_abcd);
    acc(1'b1, 16'h0100, 32'h0, 1'b1);
    chk("data", readdata_o, 32'h0);
  endtask : sc_mix
  task automatic sc_rst();
    read_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #10 {rst_i, read_i} = 2'h2;
    @(posedge ref_clk_i);
    #10 rst_i = 1'b0;
    chk("idle", {busy_o, readdata_valid_o, core_read_o}, 3'h0);
  endtask : sc_rst
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #10 rst_i = 1'b0;
    sc_mix();
    sc_rst();
    tally_and_finish();
  end
  initial begin
    #400000; // four thousand cycles, well past a normal run
    mismatches++;
    tally_and_finish();
  end
endmodule : csr_access_port_tb
